// *** src/sfsr_status_reg.sv ***
/*
 * Two-byte status register with its read-out over SPI.
 * Assumes: i_clk system clock, i_sck the SPI clock (modes 0 and 3) that
 * stands still between frames, i_cs_n and i_wp_n raw pins, and write
 * strobes and flags from same-clock logic.
 */
// What this block does
// - opcode 05h then status streams every clock
// - after byte two, restart at byte one
// - each byte freshly sampled, busy in both
// - read status accepted even while busy
// - chip select high ends read, output floats
// - byte1 bit5 shows erase/program error
// - byte1 bit4 zero while write-protect asserted
// - byte1 bits3:2 summarise software protection
// - byte1 bit1 shows write latch
// - bit0 is one while device busy
// - reserved bits read zero
// - byte2 bit4 allows soft reset command
// - byte2 bit3 allows lockdown commands
// - byte2 write changes only bits 4, 3
// - byte1 write changes lock bit, clears latch
// - lock set refuses sector protection changes
// - lock clear lets protection changes proceed
// - lock zero at power-up, soft reset keeps
// - write-protect asserted: lock only goes up
// - illegal lock clear ignored, latch cleared
module sfsr_status_reg (
  // system clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // spi pins
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  // write-protect pin, active low
  input wire logic i_wp_n,
  // device state from the array engine
  input wire sfsr_pkg::sfsr_flags_s i_flags,
  // write latch control from the command decoder
  input wire logic i_wel_set,
  input wire logic i_wel_clr,
  input wire logic i_soft_rst,
  // status byte writes
  input wire sfsr_pkg::sfsr_wr_s i_wr1,
  input wire sfsr_pkg::sfsr_wr_s i_wr2,
  // sector protection requests and global protect hand-off
  input wire logic i_sect_req,
  output logic o_sect_grant,
  output logic o_glob_stb,
  output logic [3:0] o_glob_code,
  // control bits for the rest of the device
  output logic o_lock,
  output logic o_wel,
  output logic o_rst_allow,
  output logic o_lock_allow
);

  // ************************************************************
  // system clock domain
  // ************************************************************
  logic wp_s1_q;
  logic wp_s2_q;
  logic lock_q;
  logic wel_q;
  logic rst_allow_q;
  logic lock_allow_q;
  logic glob_stb_q;
  logic [3:0] glob_code_q;
  logic [15:0] status_q;
  logic wr1_bad;

  // write-protect pin is asynchronous, two flops before use
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_s1_q <= 1'b1;
      wp_s2_q <= 1'b1;
    end else begin
      wp_s1_q <= i_wp_n;
      wp_s2_q <= wp_s1_q;
    end
  end

  // clearing the lock while the pin is asserted is refused
  assign wr1_bad = !wp_s2_q && lock_q && !i_wr1.data[sfsr_pkg::B1_LOCK];

  // lock bit: only bit 7 of a byte 1 write, soft reset never touches it
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lock_q <= sfsr_pkg::RST_LOCK;
    end else if (i_wr1.stb && !wr1_bad) begin
      lock_q <= i_wr1.data[sfsr_pkg::B1_LOCK];
    end
  end

  // write latch: any byte 1 write ends it, set wins over a same-cycle clear
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wel_q <= sfsr_pkg::RST_WEL;
    end else if (i_wel_set) begin
      wel_q <= 1'b1;
    end else if (i_wel_clr || i_soft_rst || i_wr1.stb) begin
      wel_q <= 1'b0;
    end
  end

  // byte 2 write touches only the two enables
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_allow_q <= sfsr_pkg::RST_RST_ALLOW;
      lock_allow_q <= sfsr_pkg::RST_LOCK_ALLOW;
    end else if (i_wr2.stb) begin
      rst_allow_q <= i_wr2.data[sfsr_pkg::B2_RST_ALLOW];
      lock_allow_q <= i_wr2.data[sfsr_pkg::B2_LOCK_ALLOW];
    end
  end

  // global protect runs only if the lock was clear before the write
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      glob_stb_q <= 1'b0;
      glob_code_q <= 4'h0;
    end else begin
      glob_stb_q <= i_wr1.stb && !lock_q && !wr1_bad;
      if (i_wr1.stb) begin
        glob_code_q <= i_wr1.data[5:2];
      end
    end
  end

  // sector protect and unprotect pass only while unlocked
  assign o_sect_grant = i_sect_req && !lock_q;

  // status image rebuilt every cycle so a read always sees fresh values
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      status_q <= sfsr_pkg::RST_STATUS;
    end else begin
      status_q <= 16'h0000;
      status_q[8 + sfsr_pkg::B1_LOCK] <= lock_q;
      status_q[8 + sfsr_pkg::B1_EPE] <= i_flags.erase_program_error;
      status_q[8 + sfsr_pkg::B1_WPP] <= wp_s2_q;
      status_q[8 + sfsr_pkg::B1_SWP_HI] <= i_flags.soft_protect_summary[1];
      status_q[8 + sfsr_pkg::B1_SWP_LO] <= i_flags.soft_protect_summary[0];
      status_q[8 + sfsr_pkg::B1_WEL] <= wel_q;
      status_q[8 + sfsr_pkg::BX_BUSY] <= i_flags.busy;
      status_q[sfsr_pkg::B2_RST_ALLOW] <= rst_allow_q;
      status_q[sfsr_pkg::B2_LOCK_ALLOW] <= lock_allow_q;
      status_q[sfsr_pkg::BX_BUSY] <= i_flags.busy;
    end
  end

  assign o_lock = lock_q;
  assign o_wel = wel_q;
  assign o_rst_allow = rst_allow_q;
  assign o_lock_allow = lock_allow_q;
  assign o_glob_stb = glob_stb_q;
  assign o_glob_code = glob_code_q;

  // ************************************************************
  // spi clock domain
  // ************************************************************
  logic [3:0] rx_cnt_q;
  logic [6:0] op_q;
  logic read_act_q;
  logic [15:0] st_s1_q;
  logic [15:0] st_s2_q;
  logic [2:0] tx_idx_q;
  logic byte_two_q;
  logic [7:0] tx_sh_q;
  logic oe_q;

  // opcode sampled on rising edge; chip select high clears the frame
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      rx_cnt_q <= 4'h0;
      op_q <= 7'h00;
      read_act_q <= 1'b0;
    end else if (rx_cnt_q != sfsr_pkg::OPCODE_BITS) begin
      rx_cnt_q <= rx_cnt_q + 4'h1;
      op_q <= {op_q[5:0], i_si};
      // no busy gating: the read is taken whatever the array is doing
      if (rx_cnt_q == sfsr_pkg::OPCODE_BITS - 4'h1) begin
        read_act_q <= ({op_q, i_si} == sfsr_pkg::OP_READ_STATUS);
      end
    end
  end

  // status image crosses as quasi-static bits; a byte caught mid-change
  // is fixed on the next repetition, which polling hosts already expect
  always_ff @(negedge i_sck or negedge i_nrst) begin
    if (!i_nrst) begin
      st_s1_q <= sfsr_pkg::RST_STATUS;
      st_s2_q <= sfsr_pkg::RST_STATUS;
    end else begin
      st_s1_q <= status_q;
      st_s2_q <= st_s1_q;
    end
  end

  // output shifter: loads a fresh byte at each boundary, MSB first
  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      tx_idx_q <= 3'h0;
      byte_two_q <= 1'b0;
      tx_sh_q <= 8'h00;
      oe_q <= 1'b0;
    end else if (read_act_q) begin
      oe_q <= 1'b1;
      if (tx_idx_q == 3'h0) begin
        tx_sh_q <= byte_two_q ? st_s2_q[7:0] : st_s2_q[15:8];
        byte_two_q <= !byte_two_q;
        tx_idx_q <= sfsr_pkg::LAST_BIT_IDX;
      end else begin
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        tx_idx_q <= tx_idx_q - 3'h1;
      end
    end
  end

  assign o_so = tx_sh_q[7];
  assign o_so_oe = oe_q;

endmodule

// *** src/sfsr_pkg.sv ***
/*
 * Constants and carriers for the serial flash status register block.
 * Assumes a command decoder on the system clock that delivers status
 * writes and sector protection requests, and an SPI host on the pins.
 */
package sfsr_pkg;

  // ************************************************************
  // opcodes and framing
  // ************************************************************
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [3:0] OPCODE_BITS = 4'h8;
  localparam logic [2:0] LAST_BIT_IDX = 3'h7;

  // ************************************************************
  // byte 1 field positions
  // ************************************************************
  localparam int B1_LOCK = 7;
  localparam int B1_EPE = 5;
  localparam int B1_WPP = 4;
  localparam int B1_SWP_HI = 3;
  localparam int B1_SWP_LO = 2;
  localparam int B1_WEL = 1;
  localparam int BX_BUSY = 0;

  // ************************************************************
  // byte 2 field positions
  // ************************************************************
  localparam int B2_RST_ALLOW = 4;
  localparam int B2_LOCK_ALLOW = 3;

  // ************************************************************
  // values after power-up
  // ************************************************************
  localparam logic RST_LOCK = 1'b0;
  localparam logic RST_WEL = 1'b0;
  localparam logic RST_RST_ALLOW = 1'b0;
  localparam logic RST_LOCK_ALLOW = 1'b0;
  localparam logic [15:0] RST_STATUS = 16'h0000;
  localparam logic [1:0] SWP_ALL = 2'h3;

  // ************************************************************
  // carriers
  // ************************************************************
  // device state reported through byte 1 and byte 2
  typedef struct packed {
    logic busy;
    logic erase_program_error;
    logic [1:0] soft_protect_summary;
  } sfsr_flags_s;

  // one status byte write from the command decoder
  typedef struct packed {
    logic stb;
    logic [7:0] data;
  } sfsr_wr_s;

endpackage

// *** tb/sfsr_status_reg_assertions.sv ***
/* port checker for the status register block.
   assumes a bind onto sfsr_status_reg, one clock domain. */
module sfsr_status_reg_assertions (
  // clock, reset and inputs
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_cs_n,
  input wire logic i_sect_req,
  input wire logic i_wel_set,
  input wire sfsr_pkg::sfsr_wr_s i_wr1,
  input wire sfsr_pkg::sfsr_wr_s i_wr2,
  // outputs watched
  input wire logic o_so_oe,
  input wire logic o_sect_grant,
  input wire logic o_glob_stb,
  input wire logic o_lock,
  input wire logic o_wel,
  input wire logic o_rst_allow,
  input wire logic o_lock_allow
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // the grant is combinational, so it must track the lock in the same cycle
  property p_grant; o_sect_grant == (i_sect_req & !o_lock); endproperty
  a_grant: assert property (p_grant) else $error("grant wrong");
  // a byte 1 write with no set pulse in the same cycle clears the latch
  property p_wel; i_wr1.stb && !i_wel_set |=> !o_wel; endproperty
  a_wel: assert property (p_wel) else $error("latch kept");
  property p_up; i_wr1.stb && i_wr1.data[7] |=> o_lock; endproperty
  a_up: assert property (p_up) else $error("lock not set");
  property p_keep; !i_wr1.stb |=> $stable(o_lock); endproperty
  a_keep: assert property (p_keep) else $error("lock moved");
  property p_rst; i_wr2.stb |=> o_rst_allow == $past(i_wr2.data[4]); endproperty
  a_rst: assert property (p_rst) else $error("reset enable");
  property p_lck; i_wr2.stb |=> o_lock_allow == $past(i_wr2.data[3]); endproperty
  a_lck: assert property (p_lck) else $error("lockdown enable");
  property p_glob; o_glob_stb |-> $past(i_wr1.stb) && !$past(o_lock); endproperty
  a_glob: assert property (p_glob) else $error("global pulse");
  property p_float; i_cs_n |-> !o_so_oe; endproperty
  a_float: assert property (p_float) else $error("output driven");
endmodule

bind sfsr_status_reg sfsr_status_reg_assertions u_chk (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_cs_n(i_cs_n), .i_sect_req(i_sect_req), .i_wel_set(i_wel_set), .i_wr1(i_wr1),
  .i_wr2(i_wr2),
  .o_so_oe(o_so_oe), .o_sect_grant(o_sect_grant), .o_glob_stb(o_glob_stb),
  .o_lock(o_lock), .o_wel(o_wel), .o_rst_allow(o_rst_allow), .o_lock_allow(o_lock_allow));

// *** tb/sfsr_spi_host.sv ***
/* spi host model driving the status read-out.
   assumes mode 0: clock low and still between frames. */
module sfsr_spi_host (
  // pins toward the device
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_so_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  // opcode then nb bits; a released line has no pull, so it shows the inverse,
  // and drv counts the bits during which the device really drove the line
  task automatic xfer(input logic [7:0] op, input int nb, output logic [31:0] rx,
    output int drv);
    rx = '0;
    drv = 0;
    o_cs_n = 1'b0;
    for (int i = 0; i < 8 + nb; i++) begin
      o_si = (i < 8) ? op[7 - i] : ~o_si;
      #7.5 o_sck = 1'b1;
      if (i >= 8) begin
        rx = {rx[30:0], i_so_oe ? i_so : !i_so};
        drv += int'(i_so_oe);
      end
      #7.5 o_sck = 1'b0;
    end
    #7.5 o_cs_n = 1'b1;
  endtask
endmodule

// *** tb/sfsr_status_reg_tb.sv ***
/* self-checking bench for the status register block.
   assumes the spi host model and the bound checker. */
module sfsr_status_reg_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk, i_nrst, i_wp_n, i_wel_set, i_wel_clr, i_soft_rst, i_sect_req;
  int drv;
  logic sck, cs_n, si, so, so_oe, grant, glob, lock, write_latch, rst_en, lck_en;
  logic [3:0] gcode;
  logic [31:0] rx;
  sfsr_pkg::sfsr_flags_s flags;
  sfsr_pkg::sfsr_wr_s wr1, wr2;
  int bad_count, check_count;
  sfsr_status_reg dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_sck(sck), .i_cs_n(cs_n),
    .i_si(si), .o_so(so), .o_so_oe(so_oe), .i_wp_n(i_wp_n), .i_flags(flags),
    .i_wel_set(i_wel_set), .i_wel_clr(i_wel_clr), .i_soft_rst(i_soft_rst), .i_wr1(wr1),
    .i_wr2(wr2), .i_sect_req(i_sect_req), .o_sect_grant(grant), .o_glob_stb(glob),
    .o_glob_code(gcode), .o_lock(lock), .o_wel(write_latch), .o_rst_allow(rst_en),
    .o_lock_allow(lck_en));
  sfsr_spi_host host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(so_oe));
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle strobe; outputs are settled at the negedge it returns on
  task automatic wr(input logic sel, input logic [7:0] d);
    @(negedge i_clk);
    if (sel) begin
      wr2 = '{1'b1, d};
    end else begin
      wr1 = '{1'b1, d};
    end
    @(negedge i_clk);
    wr1.stb = 1'b0;
    wr2.stb = 1'b0;
  endtask
  // four bytes: byte one, byte two, then the pair again
  task automatic rd(input logic [15:0] exp);
    host.xfer(8'h05, 32, rx, drv);
    chk(rx, {exp, exp});
    chk(32'(drv), 32'h0000_0020);
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // whole run is a few microseconds; this only cuts a hang short
  initial begin
    #100us;
    bad_count++;
    report_and_stop;
  end
  // ****************
  // sequence
  // ****************
  initial begin
    {i_nrst, i_wel_set, i_wel_clr, i_soft_rst, i_sect_req} = '0;
    i_wp_n = 1'b1;
    flags = '{1'b1, 1'b0, 2'h3};
    wr1 = '0;
    wr2 = '0;
    bad_count = 0;
    check_count = 0;
    repeat (5) @(negedge i_clk);
    i_nrst = 1'b1;
    repeat (3) @(negedge i_clk);
    rd(16'h1d01);
    wr(1'b1, 8'hff);
    rd(16'h1d19);
    @(negedge i_clk) i_wel_set = 1'b1;
    @(negedge i_clk) i_wel_set = 1'b0;
    flags = '{1'b0, 1'b1, 2'h1};
    repeat (4) @(negedge i_clk);
    rd(16'h3618);
    wr(1'b0, 8'h80);
    chk(32'({glob, gcode, lock, write_latch}), 32'h0000_0042);
    // set and clear of the latch in one cycle: set wins
    @(negedge i_clk) {i_wel_set, i_wel_clr} = 2'h3;
    @(negedge i_clk) {i_wel_set, i_wel_clr} = 2'h0;
    chk(32'(write_latch), 32'h0000_0001);
    {i_wp_n, i_sect_req, i_soft_rst} = 3'h3;
    @(negedge i_clk) i_soft_rst = 1'b0;
    chk(32'({lock, write_latch}), 32'h0000_0002);
    @(negedge i_clk) i_wel_set = 1'b1;
    @(negedge i_clk) {i_wel_set, i_wel_clr} = 2'h1;
    @(negedge i_clk) i_wel_clr = 1'b0;
    chk(32'(write_latch), 32'h0000_0000);
    @(negedge i_clk) i_wel_set = 1'b1;
    @(negedge i_clk) i_wel_set = 1'b0;
    wr(1'b0, 8'h00);
    chk(32'({glob, lock, write_latch, grant}), 32'h0000_0004);
    rd(16'ha418);
    i_wp_n = 1'b1;
    repeat (3) @(negedge i_clk);
    wr(1'b0, 8'h3c);
    chk(32'({glob, lock, grant}), 32'h0000_0001);
    wr(1'b0, 8'h3c);
    chk(32'({glob, gcode, lock}), 32'h0000_003e);
    host.xfer(8'h05, 3, rx, drv);
    chk(32'(drv), 32'h0000_0003);
    @(negedge i_clk);
    chk(32'(so_oe), 32'h0000_0000);
    host.xfer(8'h9f, 8, rx, drv);
    chk(32'(drv), 32'h0000_0000);
    report_and_stop;
  end
endmodule
